// ==== verilog/irf_core.sv ====
// Interrupt request flag logic: control registers, priority choice, acknowledge path
`timescale 1ns/1ps
`include "irf_cfg.svh"
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RULE1 - Acknowledge fetch at 00000h clears acknowledged flag
// RULE2 - Program read of 00000h clears top enabled
// RULE3 - Software never reads address 00000h
// RULE4 - Stack pointer resets to 0000h, needs loading
// RULE5 - Source, polarity or timing change may set flag
// RULE6 - Software clears flag after changing source
// RULE7 - Software disables peripheral before changing source
// RULE8 - Each source-change step is separate write
// RULE9 - Wait three filter samples before clearing flag
// RULE10 - Rewrite control only with no request
// RULE11 - Request during non-flag rewrite is kept
// RULE12 - Clear pending flag by writing zero
// RULE13 - Delay global unmask until write takes effect
// RULE14 - Pin pulses meet minimum width
// RULE15 - Filtered pin accepted after three stable samples
// RULE16 - Request core for highest level above processor
module irf_core (
  // Clock, enable and reset
  input wire logic clk,
  input wire logic ce,
  input wire logic reset,
  // Register port
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Core handshake
  input wire logic ack,
  input wire logic [2:0] cpu_level,
  output logic irq_req,
  output logic [7:0] irq_number,
  output logic [2:0] irq_level,
  // Sources: 4 peripherals, 4 pins (ext 0..1, key 0..1)
  input wire logic [3:0] periph_event,
  input wire logic [1:0] ext_irq_pin,
  input wire logic [1:0] key_irq_pin,
  // Status interrupt
  output logic irq_out
);
  localparam int N = `IRF_NSRC;
  logic [7:0] ctrl_r [N];
  logic [N-1:0] hw_set;
  logic [N-1:0] pin_ev;
  logic [N-1:0] src_change;
  logic [2:0] stat_r;
  logic [2:0] mask_r;
  logic [15:0] sp_r;
  logic sp_loaded_r;
  logic [7:0] div_r;
  logic [7:0] divc_r;
  logic tick_r;
  irf_pkg::irf_vec_s best;
  irf_pkg::irf_state_e state_r;
  logic [2:0] ev;
  logic [2:0] win;
  logic [7:0] rd_nxt;
  logic vec_read;
  logic [N-1:0] clr_vec;
  logic [3:0] pin_in;

  function automatic logic is_ctrl(input logic [15:0] a);
    return a >= `IRF_CTRL_BASE && a < `IRF_CTRL_BASE + 16'(N);
  endfunction

  function automatic logic [2:0] ctrl_idx(input logic [15:0] a);
    return 3'(a - `IRF_CTRL_BASE);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Filter sample clock divider
  always_ff @(posedge clk) begin
    if (reset) begin
      divc_r <= 8'h00;
      tick_r <= 1'b0;
    end else if (ce) begin
      tick_r <= (divc_r == div_r);
      divc_r <= (divc_r == div_r) ? 8'h00 : divc_r + 8'h01;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_pin
      irf_pin_filter u_filt (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .sample_tick(tick_r),
        .filt_en(ctrl_r[4+g][`IRF_PIN_FILT_BIT]),
        .active_high(ctrl_r[4+g][`IRF_PIN_POL_BIT]),
        .pin(pin_in[g]),
        .edge_pulse(pin_ev[4+g])
      );
    end
  endgenerate
  assign pin_ev[3:0] = 4'h0;
  assign pin_in = {key_irq_pin, ext_irq_pin};

  // A polarity change alters the pin's source and may raise a flag
  always_comb begin
    src_change = '0;
    for (int i = 4; i < N; i++) begin
      src_change[i] = wr && is_ctrl(addr) && ctrl_idx(addr) == 3'(i) &&
        (wdata[`IRF_PIN_POL_BIT] != ctrl_r[i][`IRF_PIN_POL_BIT]); // [RULE5]
    end
    hw_set = {pin_ev[7:4], periph_event} | src_change;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Priority choice over set flags above processor level
  always_comb begin
    best = '0;
    for (int i = 0; i < N; i++) begin
      if (ctrl_r[i][`IRF_FLAG_BIT] && ctrl_r[i][2:0] > cpu_level &&
          (!best.valid || ctrl_r[i][2:0] > best.level)) begin // [RULE16]
        best.valid = 1'b1;
        best.level = ctrl_r[i][2:0];
        best.number = 8'(i);
      end
    end
  end

  assign vec_read = rd && addr == `IRF_VEC_ADDR;
  always_comb begin
    clr_vec = '0;
    if (vec_read && best.valid) begin
      clr_vec[best.number[2:0]] = 1'b1; // [RULE1] [RULE2]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers; hardware set wins over any write
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < N; i++) begin
        ctrl_r[i] <= 8'h00;
      end
    end else if (ce) begin
      for (int i = 0; i < N; i++) begin
        if (wr && is_ctrl(addr) && ctrl_idx(addr) == 3'(i)) begin
          ctrl_r[i] <= wdata;
          // A write clears the flag only with zero; writing one keeps old value
          ctrl_r[i][`IRF_FLAG_BIT] <= ctrl_r[i][`IRF_FLAG_BIT] & wdata[`IRF_FLAG_BIT]; // [RULE12]
        end
        if (clr_vec[i]) begin
          ctrl_r[i][`IRF_FLAG_BIT] <= 1'b0;
        end
        if (hw_set[i]) begin
          ctrl_r[i][`IRF_FLAG_BIT] <= 1'b1; // [RULE11]
        end
      end
    end
  end

  // Stack pointer and filter sample divider
  always_ff @(posedge clk) begin
    if (reset) begin
      sp_r <= `IRF_SP_RESET; // [RULE4]
      sp_loaded_r <= 1'b0;
      div_r <= 8'h00;
    end else if (ce) begin
      if (wr && addr == `IRF_SP_ADDR) begin
        sp_r <= {sp_r[7:0], wdata};
        sp_loaded_r <= 1'b1;
      end
      if (wr && addr == `IRF_FILT_DIV_ADDR) begin
        div_r <= wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Core request handshake
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= irf_pkg::IRF_ST_IDLE;
      irq_req <= 1'b0;
      irq_number <= 8'h00;
      irq_level <= 3'd0;
    end else if (ce) begin
      unique case (state_r)
        irf_pkg::IRF_ST_IDLE: begin
          if (best.valid && sp_loaded_r) begin // [RULE4]
            state_r <= irf_pkg::IRF_ST_REQ;
            irq_req <= 1'b1;
            irq_number <= best.number;
            irq_level <= best.level;
          end
        end
        irf_pkg::IRF_ST_REQ: begin
          irq_number <= best.number;
          irq_level <= best.level;
          if (ack) begin
            state_r <= irf_pkg::IRF_ST_ACK;
          end else if (!best.valid) begin
            state_r <= irf_pkg::IRF_ST_IDLE;
            irq_req <= 1'b0;
          end
        end
        irf_pkg::IRF_ST_ACK: begin
          if (vec_read) begin
            state_r <= irf_pkg::IRF_ST_IDLE;
            irq_req <= 1'b0;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status events and interrupt
  assign ev[`IRF_EV_SPURIOUS] = |src_change;
  assign ev[`IRF_EV_VECREAD] = vec_read && state_r != irf_pkg::IRF_ST_ACK;
  assign ev[`IRF_EV_BADSP] = best.valid && !sp_loaded_r;
  assign win = (wr && addr == `IRF_STAT_ADDR) ? wdata[2:0] : 3'b000;

  always_ff @(posedge clk) begin
    if (reset) begin
      stat_r <= 3'b000;
      mask_r <= 3'b000;
      irq_out <= 1'b0;
    end else if (ce) begin
      stat_r <= (stat_r & ~win) | ev;
      if (wr && addr == `IRF_MASK_ADDR) begin
        mask_r <= wdata[2:0];
      end
      irq_out <= |(((stat_r & ~win) | ev) & mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  always_comb begin
    rd_nxt = 8'h00;
    if (addr == `IRF_VEC_ADDR) begin
      rd_nxt = best.valid ? {best.number[4:0], best.level} : 8'h00;
    end else if (is_ctrl(addr)) begin
      rd_nxt = ctrl_r[ctrl_idx(addr)];
    end else if (addr == `IRF_STAT_ADDR) begin
      rd_nxt = {5'd0, stat_r};
    end else if (addr == `IRF_MASK_ADDR) begin
      rd_nxt = {5'd0, mask_r};
    end else if (addr == `IRF_SP_ADDR) begin
      rd_nxt = sp_r[7:0];
    end else if (addr == `IRF_FILT_DIV_ADDR) begin
      rd_nxt = div_r;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= rd ? rd_nxt : 8'h00;
    end
  end

  a_vec_clears: assert property (@(posedge clk) disable iff (reset) // [RULE2]
    ce && vec_read && best.valid && !hw_set[best.number[2:0]] |=>
    !ctrl_r[$past(best.number[2:0])][`IRF_FLAG_BIT])
    else $error("vector read did not clear flag");
  a_req_level: assert property (@(posedge clk) disable iff (reset) // [RULE16]
    irq_req && state_r == irf_pkg::IRF_ST_REQ |->
    irq_level > $past(cpu_level) || !$past(ce))
    else $error("request at or below processor level");
  a_sp_block: assert property (@(posedge clk) disable iff (reset) // [RULE4]
    !sp_loaded_r |-> !irq_req)
    else $error("request before stack pointer loaded");
  a_set_wins: assert property (@(posedge clk) disable iff (reset) // [RULE11]
    ce && hw_set[0] |=> ctrl_r[0][`IRF_FLAG_BIT])
    else $error("hardware set lost");
  a_pol_spur: assert property (@(posedge clk) disable iff (reset) // [RULE5]
    ce && src_change[4] |=> ctrl_r[4][`IRF_FLAG_BIT])
    else $error("source change did not set flag");
  a_one_keeps: assert property (@(posedge clk) disable iff (reset) // [RULE12]
    ce && wr && addr == `IRF_CTRL_BASE && !ctrl_r[0][`IRF_FLAG_BIT] && !hw_set[0] |=>
    !ctrl_r[0][`IRF_FLAG_BIT])
    else $error("write of one set flag");
  a_ack_fetch: assert property (@(posedge clk) disable iff (reset) // [RULE1]
    ce && state_r == irf_pkg::IRF_ST_ACK && vec_read |=> !irq_req)
    else $error("request held after acknowledge fetch");
  a_irq_level: assert property (@(posedge clk) disable iff (reset) // [RULE5]
    ce && |(stat_r & mask_r) && win == 3'b000 |=> irq_out)
    else $error("interrupt output low with unmasked status");
endmodule

// ==== verilog/irf_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the request flag logic
`ifndef IRF_CFG_SVH
`define IRF_CFG_SVH
`define IRF_NSRC 8
`define IRF_ADDR_W 16
`define IRF_VEC_ADDR 16'h0000
`define IRF_CTRL_BASE 16'h0050
`define IRF_TRA_CTRL 16'h0056
`define IRF_STAT_ADDR 16'h0060
`define IRF_MASK_ADDR 16'h0061
`define IRF_SP_ADDR 16'h0062
`define IRF_FILT_DIV_ADDR 16'h0063
`define IRF_FLAG_BIT 3
`define IRF_LVL_LSB 0
`define IRF_PIN_POL_BIT 4
`define IRF_PIN_FILT_BIT 5
`define IRF_SP_RESET 16'h0000
`define IRF_FILT_STABLE 3
`define IRF_EV_SPURIOUS 0
`define IRF_EV_VECREAD 1
`define IRF_EV_BADSP 2
`endif

// ==== verilog/irf_pkg.sv ====
// Types shared by the request flag logic
package irf_pkg;
  typedef struct packed {
    logic [7:0] number;
    logic [2:0] level;
    logic valid;
  } irf_vec_s;
  typedef enum logic [1:0] {
    IRF_ST_IDLE,
    IRF_ST_REQ,
    IRF_ST_ACK
  } irf_state_e;
endpackage

// ==== verilog/irf_pin_filter.sv ====
// Synchroniser, optional three-sample digital filter and edge detect for one pin
`timescale 1ns/1ps
`include "irf_cfg.svh"
module irf_pin_filter (
  // Clock and control
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic sample_tick,
  input wire logic filt_en,
  input wire logic active_high,
  // Pin and event
  input wire logic pin,
  output logic edge_pulse
);
  logic sync1_r;
  logic sync2_r;
  logic [1:0] cnt_r;
  logic level_r;
  logic last_r;
  logic cand;

  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else if (ce) begin
      sync1_r <= pin;
      sync2_r <= sync1_r;
    end
  end

  assign cand = active_high ? sync2_r : ~sync2_r;

  // Level accepted only after three stable samples when filtering
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_r <= 2'd0;
      // Level a cleared synchroniser shows through the reset polarity; no false edge
      level_r <= 1'b1;
    end else if (ce) begin
      if (!filt_en) begin
        level_r <= cand;
        cnt_r <= 2'd0;
      end else if (sample_tick) begin
        if (cand == level_r) begin
          cnt_r <= 2'd0;
        end else if (cnt_r == 2'(`IRF_FILT_STABLE - 1)) begin
          level_r <= cand; // [RULE15]
          cnt_r <= 2'd0;
        end else begin
          cnt_r <= cnt_r + 2'd1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      last_r <= 1'b1;
      edge_pulse <= 1'b0;
    end else if (ce) begin
      last_r <= level_r;
      edge_pulse <= level_r & ~last_r;
    end
  end
endmodule

// ==== bench/irf_src_model.sv ====
// Peripheral and pin source model driving the request inputs
`timescale 1ns/1ps
module irf_src_model #(parameter int MIN_W = 2) (
  // Clock
  input wire logic clk,
  // Commands from the bench
  input wire logic [3:0] periph_go,
  input wire logic [3:0] pin_go,
  input wire logic [7:0] pin_width,
  // Request lines
  output logic [3:0] periph_event,
  output logic [1:0] ext_irq_pin,
  output logic [1:0] key_irq_pin
);
  logic [7:0] cnt_r [4] = '{default: 8'h00};
  initial periph_event = 4'h0;
  always @(posedge clk) begin
    periph_event <= periph_go;
    for (int i = 0; i < 4; i++) begin
      // Pins idle low; a pulse is never shorter than the minimum width
      if (pin_go[i])
        cnt_r[i] <= (pin_width < MIN_W) ? 8'(MIN_W) : pin_width;
      else if (cnt_r[i] != 8'h00)
        cnt_r[i] <= cnt_r[i] - 8'h01;
    end
  end
  assign ext_irq_pin = {cnt_r[1] != 8'h00, cnt_r[0] != 8'h00};
  assign key_irq_pin = {cnt_r[3] != 8'h00, cnt_r[2] != 8'h00};
endmodule

// ==== bench/tb_irf_core.sv ====
// Self-checking bench for the interrupt request flag logic
`timescale 1ns/1ps
module tb_irf_core;
  logic clk;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [15:0] a;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ack = 1'b0;
  logic [2:0] cpu_level = 3'h0;
  logic [3:0] periph_go = 4'h0;
  logic [3:0] pin_go = 4'h0;
  logic [7:0] pin_width = 8'h00;
  logic [7:0] rdata, irq_number;
  logic [2:0] irq_level;
  logic irq_req, irq_out;
  logic [3:0] periph_event;
  logic [1:0] ext_pin, key_pin;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////////////
  irf_core DUT (.clk(clk), .ce(ce), .reset(reset), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .ack(ack), .cpu_level(cpu_level),
    .irq_req(irq_req), .irq_number(irq_number), .irq_level(irq_level),
    .periph_event(periph_event), .ext_irq_pin(ext_pin), .key_irq_pin(key_pin),
    .irq_out(irq_out));
  irf_src_model u_src (.clk(clk), .periph_go(periph_go), .pin_go(pin_go),
    .pin_width(pin_width), .periph_event(periph_event), .ext_irq_pin(ext_pin),
    .key_irq_pin(key_pin));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (fails == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic reg_wr(input logic [15:0] ad, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= ad;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Also drops ack, so a vector fetch follows an acknowledge with no gap
  task automatic reg_rd(input logic [15:0] ad, input logic [7:0] e);
    @(posedge clk);
    ack <= 1'b0;
    rd <= 1'b1;
    addr <= ad;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic fire(input logic [3:0] m);
    @(posedge clk);
    periph_go <= m;
    @(posedge clk);
    periph_go <= 4'h0;
  endtask
  task automatic wait_req(input logic [7:0] num, input logic [2:0] lvl);
    int n = 0;
    while (irq_req !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(8'(irq_req), 8'h01);
    chk(irq_number, num);
    chk(8'(irq_level), 8'(lvl));
  endtask
  task automatic pulse(input int i, input logic [7:0] w);
    @(posedge clk);
    pin_go <= 4'(1 << i);
    pin_width <= w;
    @(posedge clk);
    pin_go <= 4'h0;
    repeat (16) @(posedge clk);
  endtask
  // Hardware sets the flag in the very cycle software rewrites the register
  task automatic race(input logic [7:0] d, input logic [7:0] e);
    fire(4'h8);
    wr <= 1'b1;
    addr <= 16'h0053;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    reg_rd(16'h0053, e);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      $display("unexpected at %0t: timeout", $time);
      wrap_up;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    reg_rd(16'h0062, 8'h00);
    reg_rd(16'h0070, 8'h00);
    reg_wr(16'h0050, 8'h05);
    fire(4'h1);
    repeat (4) @(posedge clk);
    #1;
    chk(8'(irq_req), 8'h00);
    chk(8'(irq_out), 8'h00);
    reg_rd(16'h0060, 8'h04);
    reg_wr(16'h0061, 8'h04);
    @(posedge clk);
    #1;
    chk(8'(irq_out), 8'h01);
    reg_wr(16'h0062, 8'h00);
    reg_wr(16'h0062, 8'h40);
    reg_rd(16'h0062, 8'h40);
    reg_wr(16'h0060, 8'h04);
    @(posedge clk);
    #1;
    chk(8'(irq_out), 8'h00);
    wait_req(8'h00, 3'h5);
    @(posedge clk);
    ack <= 1'b1;
    reg_rd(16'h0000, 8'h05);
    @(posedge clk);
    #1;
    chk(8'(irq_req), 8'h00);
    reg_rd(16'h0050, 8'h05);
    // Two pending, only the higher level is offered
    cpu_level <= 3'h3;
    reg_wr(16'h0051, 8'h03);
    reg_wr(16'h0052, 8'h06);
    fire(4'h6);
    wait_req(8'h02, 3'h6);
    reg_rd(16'h0000, 8'h16);
    reg_rd(16'h0052, 8'h06);
    reg_rd(16'h0051, 8'h0b);
    reg_rd(16'h0060, 8'h02);
    chk(8'(irq_req), 8'h00);
    cpu_level <= 3'h2;
    wait_req(8'h01, 3'h3);
    reg_wr(16'h0051, 8'h0b);
    reg_rd(16'h0051, 8'h0b);
    reg_wr(16'h0051, 8'h03);
    reg_rd(16'h0051, 8'h03);
    chk(8'(irq_req), 8'h00);
    reg_wr(16'h0051, 8'h0b);
    reg_rd(16'h0051, 8'h03);
    reg_wr(16'h0060, 8'h07);
    race(8'h02, 8'h0a);
    race(8'h00, 8'h08);
    reg_wr(16'h0053, 8'h00);
    cpu_level <= 3'h7;
    for (int i = 0; i < 4; i++) begin
      a = 16'h0054 + 16'(i);
      reg_wr(a, 8'h10);
      reg_rd(a, 8'h18);
      reg_wr(a, 8'h10);
      reg_rd(a, 8'h10);
      pulse(i, 8'h03);
      reg_rd(a, 8'h18);
      reg_wr(a, 8'h10);
    end
    reg_rd(16'h0060, 8'h01);
    // Filter on the second external pin, sampled every cycle
    reg_wr(16'h0063, 8'h00);
    reg_wr(16'h0055, 8'h30);
    repeat (4) @(posedge clk);
    reg_wr(16'h0055, 8'h30);
    pulse(1, 8'h02);
    reg_rd(16'h0055, 8'h30);
    pulse(1, 8'h06);
    reg_rd(16'h0055, 8'h38);
    // A write while the enable is low must be lost
    ce <= 1'b0;
    reg_wr(16'h0063, 8'h55);
    ce <= 1'b1;
    reg_rd(16'h0063, 8'h00);
    wrap_up;
  end
endmodule
